/* File: design/rail_reset_pkg.sv */
// package for the rail enable and reset logic: modes, cause layout, reset values
// assumes a single 25 MHz clock domain and no register bus
package rail_reset_pkg;

    typedef enum logic [2:0] {
        mode_power_off = 3'h0,
        mode_sleep = 3'h1,
        mode_active = 3'h2,
        mode_passive = 3'h3
    } power_mode_e;

    typedef enum logic [2:0] {
        op_init = 3'h0,
        op_diag = 3'h1,
        op_safing = 3'h2,
        op_scrap = 3'h3,
        op_arming = 3'h4
    } op_state_e;

    // raw asynchronous error and comparator flags from the analog side
    typedef struct packed {
        logic bandgap_error;
        logic analog_reg_error;
        logic digital_reg_error;
        logic ground_error;
        logic five_volt_rail_error;
        logic three_v3_rail_error;
        logic backfeed_detect;
    } analog_flags_s;

    // regulator and switch enables
    typedef struct packed {
        logic charge_gen_en;
        logic crossover_sw_en;
        logic five_volt_rail_en;
        logic three_v3_rail_en;
        logic sensor_supply_rail_en;
        logic safing_fet_supply_en;
        logic safing_fet_25v_sel;
    } rail_enables_s;

    localparam int cause_width = 8;
    localparam int cause_bandgap = 0;
    localparam int cause_analog_reg = 1;
    localparam int cause_digital_reg = 2;
    localparam int cause_ground = 3;
    localparam int cause_five_volt = 4;
    localparam int cause_three_v3 = 5;
    localparam int cause_wdg_a = 6;
    localparam int cause_wdg_b = 7;

    localparam logic [cause_width-1:0] cause_reset_value = 8'h00;
    localparam int sync_stages = 2;

endpackage : rail_reset_pkg

/* File: design/rail_enable_and_reset_logic.sv */
// rail enables by power mode, safing fet supply enable, reset hierarchy and reset causes
// assumes mode and command inputs come from logic on clk; analog flags are asynchronous
`timescale 1ns/1ps

// Behaviour
// - charge generator on/off commands take effect only in active mode
// - outside active mode the charge generator is forced off
// - crossover switch turns on automatically on entering passive mode
// - back-feed comparator detection turns the crossover switch off
// - external crossover control output is high exactly while in passive mode
// - five volt regulator enabled in active and passive, else disabled
// - three-v3 regulator enabled in active and passive, else disabled
// - sensor supply regulator enabled in active and passive, else disabled
// - safing fet supply on for any arm signal, or high fire without low
// - safing fet supply defaults to 20 V; config bit selects 25 V
// - bandgap or regulator error raises power-on reset, forcing all resets
// - watchdog fsm reset follows power-on reset
// - system fsm reset on power-on, watchdog reset, or watchdog fsm failure
// - reset pin is the inverse of the system fsm reset
// - reset causes latch into fault status; reading it clears them
// - ground shift error enters power-on reset
// - analog and digital regulator errors combine into the regulator error
// - five volt and three-v3 rail errors feed system reset generation
// - system fsm reset returns operating state to init from any state
module rail_enable_and_reset_logic #(
    parameter int arm_count = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire rail_reset_pkg::power_mode_e power_mode,
    input wire rail_reset_pkg::analog_flags_s analog_flags,
    input wire logic charge_cmd_valid,
    input wire logic charge_cmd_on,
    input wire logic safing_25v_cfg,
    input wire logic [arm_count-1:0] internal_arm_signals,
    input wire logic high_side_fire_enable,
    input wire logic low_side_fire_enable,
    input wire logic wdg_a_fail,
    input wire logic wdg_b_fail,
    input wire logic fault_status_read,
    input wire logic go_diag,
    input wire logic go_safing,
    input wire logic go_scrap,
    input wire logic go_arming,
    input wire logic arming_exit,
    output rail_reset_pkg::rail_enables_s rail_enables,
    output logic ext_crossover_ctrl_out,
    output logic reset_n_out,
    output logic power_on_rst,
    output logic watchdog_fsm_rst,
    output logic system_fsm_rst,
    output logic internal_regulator_error,
    output logic [rail_reset_pkg::cause_width-1:0] fault_status_reg,
    output rail_reset_pkg::op_state_e op_state
);

    // refuse settings the logic cannot serve
    if (arm_count < 1) begin : g_arm_count_check
        $error("arm_count must be at least 1");
    end
    if (rail_reset_pkg::sync_stages != 2) begin : g_sync_check
        $error("the flag synchroniser is built for exactly two stages");
    end
    if (rail_reset_pkg::cause_width < 8) begin : g_cause_check
        $error("cause_width must hold all eight reset causes");
    end

    localparam int flag_w = $bits(rail_reset_pkg::analog_flags_s);

    // mode decode shared by the three regulator enables
    function automatic logic rails_wanted(input rail_reset_pkg::power_mode_e mode);
        rails_wanted = (mode == rail_reset_pkg::mode_active)
            || (mode == rail_reset_pkg::mode_passive);
    endfunction : rails_wanted

    // safing fet supply request: any arm line, or high-side fire without low-side
    function automatic logic safing_request(
        input logic [arm_count-1:0] arm,
        input logic high_fire,
        input logic low_fire
    );
        safing_request = (|arm) || (high_fire && !low_fire);
    endfunction : safing_request

    // one bit per cause, so simultaneous causes stay distinguishable
    function automatic logic [rail_reset_pkg::cause_width-1:0] cause_vector(
        input rail_reset_pkg::analog_flags_s f,
        input logic wdg_a,
        input logic wdg_b
    );
        cause_vector = '0;
        cause_vector[rail_reset_pkg::cause_bandgap] = f.bandgap_error;
        cause_vector[rail_reset_pkg::cause_analog_reg] = f.analog_reg_error;
        cause_vector[rail_reset_pkg::cause_digital_reg] = f.digital_reg_error;
        cause_vector[rail_reset_pkg::cause_ground] = f.ground_error;
        cause_vector[rail_reset_pkg::cause_five_volt] = f.five_volt_rail_error;
        cause_vector[rail_reset_pkg::cause_three_v3] = f.three_v3_rail_error;
        cause_vector[rail_reset_pkg::cause_wdg_a] = wdg_a;
        cause_vector[rail_reset_pkg::cause_wdg_b] = wdg_b;
    endfunction : cause_vector

    // wdg failures come from the same clock; only analog flags are synchronised
    logic [flag_w-1:0] flag_meta;
    logic [flag_w-1:0] flag_sync;
    rail_reset_pkg::analog_flags_s flags;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag_meta <= '0;
            flag_sync <= '0;
        end else begin
            flag_meta <= analog_flags;
            flag_sync <= flag_meta;
        end
    end

    assign flags = rail_reset_pkg::analog_flags_s'(flag_sync);

    logic is_active;
    logic is_passive;
    logic in_passive_prev;
    assign is_active = (power_mode == rail_reset_pkg::mode_active);
    assign is_passive = (power_mode == rail_reset_pkg::mode_passive);

    // charge generator
    logic charge_gen;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            charge_gen <= 1'b0;
        end else if (!is_active) begin
            charge_gen <= 1'b0;
        end else if (charge_cmd_valid) begin
            charge_gen <= charge_cmd_on;
        end
    end

    // crossover switch: turn-off by back-feed wins over the entry event
    logic crossover_sw;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            in_passive_prev <= 1'b0;
            crossover_sw <= 1'b0;
        end else begin
            in_passive_prev <= is_passive;
            if (flags.backfeed_detect || !is_passive) begin
                crossover_sw <= 1'b0;
            end else if (!in_passive_prev) begin
                crossover_sw <= 1'b1;
            end
        end
    end

    // one output flop per enable, so no decode glitch ever reaches a regulator pin
    logic charge_gen_en;
    logic crossover_sw_en;
    logic five_volt_rail_en;
    logic three_v3_rail_en;
    logic sensor_supply_rail_en;
    logic safing_fet_supply_en;
    logic safing_fet_25v_sel;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            charge_gen_en <= 1'b0;
        end else begin
            charge_gen_en <= charge_gen;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            crossover_sw_en <= 1'b0;
        end else begin
            crossover_sw_en <= crossover_sw;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            five_volt_rail_en <= 1'b0;
        end else begin
            five_volt_rail_en <= rails_wanted(power_mode);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            three_v3_rail_en <= 1'b0;
        end else begin
            three_v3_rail_en <= rails_wanted(power_mode);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sensor_supply_rail_en <= 1'b0;
        end else begin
            sensor_supply_rail_en <= rails_wanted(power_mode);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            safing_fet_supply_en <= 1'b0;
        end else begin
            safing_fet_supply_en <= safing_request(internal_arm_signals,
                high_side_fire_enable, low_side_fire_enable);
        end
    end

    // zero out of reset selects the 20 V setting
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            safing_fet_25v_sel <= 1'b0;
        end else begin
            safing_fet_25v_sel <= safing_25v_cfg;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_crossover_ctrl_out <= 1'b0;
        end else begin
            ext_crossover_ctrl_out <= is_passive;
        end
    end

    always_comb begin
        rail_enables.charge_gen_en = charge_gen_en;
        rail_enables.crossover_sw_en = crossover_sw_en;
        rail_enables.five_volt_rail_en = five_volt_rail_en;
        rail_enables.three_v3_rail_en = three_v3_rail_en;
        rail_enables.sensor_supply_rail_en = sensor_supply_rail_en;
        rail_enables.safing_fet_supply_en = safing_fet_supply_en;
        rail_enables.safing_fet_25v_sel = safing_fet_25v_sel;
    end

    // reset hierarchy, combinational from synchronised flags
    logic reg_err;
    logic por;
    logic wsm_rst;
    logic ssm_rst;
    assign reg_err = flags.analog_reg_error || flags.digital_reg_error;
    assign por = flags.bandgap_error || reg_err || flags.ground_error;
    assign wsm_rst = por;
    // rail errors act on the system reset like the watchdog failures
    assign ssm_rst = por || wsm_rst || wdg_a_fail || wdg_b_fail
        || flags.five_volt_rail_error || flags.three_v3_rail_error;

    // each reset output on its own flop; all stand asserted while nrst is low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            power_on_rst <= 1'b1;
        end else begin
            power_on_rst <= por;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            watchdog_fsm_rst <= 1'b1;
        end else begin
            watchdog_fsm_rst <= wsm_rst;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            system_fsm_rst <= 1'b1;
        end else begin
            system_fsm_rst <= ssm_rst;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reset_n_out <= 1'b0;
        end else begin
            reset_n_out <= !ssm_rst;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            internal_regulator_error <= 1'b0;
        end else begin
            internal_regulator_error <= reg_err;
        end
    end

    // reset causes; a new cause in the read cycle survives the clear
    logic [rail_reset_pkg::cause_width-1:0] cause_now;
    assign cause_now = cause_vector(flags, wdg_a_fail, wdg_b_fail);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fault_status_reg <= rail_reset_pkg::cause_reset_value;
        end else if (fault_status_read) begin
            fault_status_reg <= cause_now;
        end else begin
            fault_status_reg <= fault_status_reg | cause_now;
        end
    end

    // operating state, held in init while the system reset stands
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            op_state <= rail_reset_pkg::op_init;
        end else if (ssm_rst) begin
            op_state <= rail_reset_pkg::op_init;
        end else begin
            case (op_state)
                rail_reset_pkg::op_init: begin
                    if (go_diag) begin
                        op_state <= rail_reset_pkg::op_diag;
                    end
                end
                rail_reset_pkg::op_diag: begin
                    if (go_safing) begin
                        op_state <= rail_reset_pkg::op_safing;
                    end else if (go_scrap) begin
                        op_state <= rail_reset_pkg::op_scrap;
                    end
                end
                rail_reset_pkg::op_safing: begin
                    op_state <= rail_reset_pkg::op_safing;
                end
                rail_reset_pkg::op_scrap: begin
                    if (go_arming) begin
                        op_state <= rail_reset_pkg::op_arming;
                    end
                end
                rail_reset_pkg::op_arming: begin
                    if (arming_exit) begin
                        op_state <= rail_reset_pkg::op_scrap;
                    end
                end
                default: begin
                    op_state <= rail_reset_pkg::op_init;
                end
            endcase
        end
    end

endmodule : rail_enable_and_reset_logic

/* File: sim/rail_reset_checker.sv */
// checker: rail enables, reset hierarchy and cause latching
// assumes it is bound into the rail logic top, one clk domain
`timescale 1ns/1ps
module rail_reset_checker #(
    parameter int arm_count = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire rail_reset_pkg::power_mode_e power_mode,
    input wire rail_reset_pkg::analog_flags_s analog_flags,
    input wire logic [arm_count-1:0] internal_arm_signals,
    input wire logic high_side_fire_enable,
    input wire logic low_side_fire_enable,
    input wire logic wdg_a_fail,
    input wire rail_reset_pkg::rail_enables_s rail_enables,
    input wire logic ext_crossover_ctrl_out,
    input wire logic reset_n_out,
    input wire logic power_on_rst,
    input wire logic watchdog_fsm_rst,
    input wire logic system_fsm_rst,
    input wire logic [rail_reset_pkg::cause_width-1:0] fault_status_reg,
    input wire rail_reset_pkg::op_state_e op_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // two sync stages plus the output flop; one cycle slack on where the flag lands
    property por_cause(logic f);
        $rose(f) |-> ##[2:4] power_on_rst;
    endproperty
    bandgap_por_a: assert property (por_cause(analog_flags.bandgap_error))
        else $error("bandgap error without power-on reset");
    ground_por_a: assert property (por_cause(analog_flags.ground_error))
        else $error("ground error without power-on reset");
    wsm_under_por_a: assert property (power_on_rst |-> watchdog_fsm_rst)
        else $error("watchdog reset low under power-on reset");
    ssm_cause_a: assert property ((power_on_rst || watchdog_fsm_rst) |-> system_fsm_rst)
        else $error("system reset low under a higher reset");
    wdg_fail_a: assert property (wdg_a_fail |=>
        system_fsm_rst && fault_status_reg[rail_reset_pkg::cause_wdg_a])
        else $error("watchdog failure not seen on reset or cause");
    pin_inverse_a: assert property (reset_n_out == !system_fsm_rst)
        else $error("reset pin not inverse of system reset");
    rails_mode_a: assert property ($past(nrst) |->
        rail_enables[4:2] == {3{$past(power_mode[1])}})
        else $error("rail enables disagree with mode");
    crossover_out_a: assert property ($past(nrst) |->
        ext_crossover_ctrl_out == ($past(power_mode) == rail_reset_pkg::mode_passive))
        else $error("crossover output disagrees with mode");
    charge_off_a: assert property ((power_mode != rail_reset_pkg::mode_active)[*2] |=>
        !rail_enables.charge_gen_en)
        else $error("charge generator on outside active");
    safing_fet_a: assert property ($past(nrst) |-> rail_enables.safing_fet_supply_en ==
        $past(|internal_arm_signals || (high_side_fire_enable && !low_side_fire_enable)))
        else $error("safing supply enable wrong");
    op_reset_a: assert property (system_fsm_rst |-> op_state == rail_reset_pkg::op_init)
        else $error("operating state not init under system reset");
    cover property (op_state == rail_reset_pkg::op_safing);
    cover property ($rose(power_on_rst));
    cover property ($fell(rail_enables.crossover_sw_en));
    cover property (op_state == rail_reset_pkg::op_arming);
endmodule : rail_reset_checker

bind rail_enable_and_reset_logic rail_reset_checker #(.arm_count(arm_count)) rail_reset_checker_i (.*);

/* File: sim/mcu_model.sv */
// microcontroller side: turns a read request into one fault status read strobe
// assumes rd_req is raised for one cycle by the bench
`timescale 1ns/1ps
module mcu_model (
    input wire logic clk,
    input wire logic rd_req,
    input wire logic [7:0] fault_status_reg,
    output logic fault_status_read = 1'b0,
    output logic [7:0] rd_data = 8'h00
);
    // data is taken at the edge the device sees the strobe, before its clear lands
    always @(posedge clk) begin
        if (fault_status_read) begin
            rd_data <= fault_status_reg;
        end
        fault_status_read <= rd_req && !fault_status_read;
    end
endmodule : mcu_model

/* File: sim/rail_enable_and_reset_logic_bench.sv */
// bench: drives modes, flags and commands; checks rails, resets and latched causes
// assumes the mcu model performs the fault status reads
`timescale 1ns/1ps
module rail_enable_and_reset_logic_bench;
    logic clk = 1'b0, nrst = 1'b0, charge_cmd_valid = 1'b0, charge_cmd_on = 1'b1;
    logic safing_25v_cfg = 1'b0, high_side_fire_enable = 1'b0, low_side_fire_enable = 1'b0;
    logic wdg_a_fail = 1'b0, wdg_b_fail = 1'b0, go_diag = 1'b0, go_safing = 1'b0;
    logic go_scrap = 1'b0, go_arming = 1'b0, arming_exit = 1'b0, rd_req = 1'b0;
    logic [3:0] internal_arm_signals = 4'h0;
    rail_reset_pkg::power_mode_e power_mode = rail_reset_pkg::mode_active;
    rail_reset_pkg::analog_flags_s analog_flags = '0;
    rail_reset_pkg::rail_enables_s rail_enables;
    rail_reset_pkg::op_state_e op_state;
    logic ext_crossover_ctrl_out, reset_n_out, power_on_rst, watchdog_fsm_rst, system_fsm_rst;
    logic internal_regulator_error, fault_status_read;
    logic [7:0] fault_status_reg, rd_data;
    logic [3:0] rst_view;
    int errors = 0, checked = 0, cycles = 0;
    assign rst_view = {power_on_rst, watchdog_fsm_rst, system_fsm_rst, reset_n_out};
    rail_enable_and_reset_logic rail_enable_and_reset_logic_i (.*);
    mcu_model mcu_model_i (.*);
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic test_done();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask : w
    task automatic read_causes(input logic [7:0] exp);
        rd_req <= 1'b1;
        w(1);
        rd_req <= 1'b0;
        w(2);
        chk(rd_data, exp);
    endtask : read_causes
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        w(5);
        nrst <= 1'b1;
        w(2);
        for (int m = 0; m < 4; m++) begin
            power_mode <= rail_reset_pkg::power_mode_e'(m);
            w(4);
            chk(8'(rail_enables[4:2]), m[1] ? 8'h07 : 8'h00);
            chk(8'(ext_crossover_ctrl_out), 8'(m == rail_reset_pkg::mode_passive));
        end
        chk(8'(rail_enables.crossover_sw_en), 8'h01);
        analog_flags <= 7'h01;
        w(6);
        analog_flags <= '0;
        w(6);
        chk(8'(rail_enables.crossover_sw_en), 8'h00);
        // an on command in sleep must not survive the return to active
        power_mode <= rail_reset_pkg::mode_sleep;
        charge_cmd_valid <= 1'b1;
        w(1);
        power_mode <= rail_reset_pkg::mode_active;
        charge_cmd_valid <= 1'b0;
        w(4);
        chk(8'(rail_enables.charge_gen_en), 8'h00);
        // on, off, then on again so the passive check below starts from on
        for (int k = 0; k < 3; k++) begin
            charge_cmd_on <= (k != 1);
            charge_cmd_valid <= 1'b1;
            w(1);
            charge_cmd_valid <= 1'b0;
            w(4);
            chk(8'(rail_enables.charge_gen_en), 8'(k != 1));
        end
        power_mode <= rail_reset_pkg::mode_passive;
        w(4);
        chk(8'(rail_enables.charge_gen_en), 8'h00);
        for (int i = 0; i < 8; i++) begin
            internal_arm_signals <= i[2] ? 4'h4 : 4'h0;
            high_side_fire_enable <= i[1];
            low_side_fire_enable <= i[0];
            safing_25v_cfg <= i[0];
            w(3);
            chk(8'(rail_enables[1:0]), 8'({i[2] | (i[1] & !i[0]), i[0]}));
        end
        go_diag <= 1'b1;
        w(1);
        go_diag <= 1'b0;
        go_safing <= 1'b1;
        w(1);
        go_safing <= 1'b0;
        w(3);
        chk(8'(op_state), 8'(rail_reset_pkg::op_safing));
        wdg_a_fail <= 1'b1;
        w(1);
        wdg_a_fail <= 1'b0;
        wdg_b_fail <= 1'b1;
        w(1);
        wdg_b_fail <= 1'b0;
        chk(8'(rst_view), 8'h02);
        chk(8'(op_state), 8'(rail_reset_pkg::op_init));
        read_causes(8'hc0);
        go_diag <= 1'b1;
        w(1);
        go_diag <= 1'b0;
        go_scrap <= 1'b1;
        w(1);
        go_scrap <= 1'b0;
        go_arming <= 1'b1;
        w(1);
        go_arming <= 1'b0;
        w(2);
        chk(8'(op_state), 8'(rail_reset_pkg::op_arming));
        arming_exit <= 1'b1;
        w(1);
        arming_exit <= 1'b0;
        w(2);
        chk(8'(op_state), 8'(rail_reset_pkg::op_scrap));
        go_arming <= 1'b1;
        w(1);
        go_arming <= 1'b0;
        w(2);
        chk(8'(op_state), 8'(rail_reset_pkg::op_arming));
        for (int j = 6; j > 0; j--) begin
            analog_flags <= 7'(1 << j);
            w(6);
            chk(8'(rst_view), j > 2 ? 8'h0e : 8'h02);
            chk(8'(internal_regulator_error), 8'(j == 5 || j == 4));
            chk(8'(op_state), 8'(rail_reset_pkg::op_init));
            analog_flags <= '0;
            w(6);
            read_causes(8'(1 << (6 - j)));
        end
        analog_flags <= 7'h0c;
        w(3);
        analog_flags <= '0;
        w(6);
        read_causes(8'h18);
        read_causes(8'h00);
        test_done();
    end
endmodule : rail_enable_and_reset_logic_bench
